//--- line_listener.sv
`timescale 1ns/1ps
module line_listener (
  // clock and lines
  input wire mclk,
  input wire [7:0] lines,
  // last level seen
  output reg [7:0] seen
);
  // trigger input only samples, it never loads the lines
  always @(posedge mclk) seen <= lines;
endmodule // line_listener

//--- segment_value_store.v
`timescale 1ns/1ps
`include "state_lines_regs.vh"
// per channel, per segment four-bit store; read and lookup ports are registered
module segment_value_store (
  // clock and reset
  input wire mclk,
  input wire srst,
  // software write
  input wire wr,
  input wire [`CHAN_AW-1:0] wr_chan,
  input wire [`SEG_AW-1:0] wr_seg,
  input wire [`SEG_VAL_W-1:0] wr_data,
  // software read
  input wire [`CHAN_AW-1:0] rd_chan,
  input wire [`SEG_AW-1:0] rd_seg,
  output reg [`SEG_VAL_W-1:0] rd_data,
  // sequencer lookup
  input wire [`CHAN_AW-1:0] lk_chan,
  input wire [`SEG_AW-1:0] lk_seg,
  output reg [`SEG_VAL_W-1:0] lk_data
);
  localparam DEPTH = `CHAN_COUNT * `SEG_COUNT;
  reg [`SEG_VAL_W-1:0] mem [0:DEPTH-1];
  integer i;

  // flops, not ram: reset must clear every entry at once
  always @(posedge mclk) begin
    if (srst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= `SEG_VAL_RST;
      end
      rd_data <= `SEG_VAL_RST;
      lk_data <= `SEG_VAL_RST;
    end else begin
      if (wr) begin
        mem[{wr_chan, wr_seg}] <= wr_data;
      end
      rd_data <= mem[{rd_chan, rd_seg}];
      lk_data <= mem[{lk_chan, lk_seg}];
    end
  end
endmodule // segment_value_store

//--- state_lines_regs.vh
`ifndef STATE_LINES_REGS_VH
`define STATE_LINES_REGS_VH
// channel and segment counts, address widths
`define CHAN_COUNT 16
`define CHAN_AW 4
`define SEG_COUNT 16
`define SEG_AW 4
// value widths
`define CHAN_VAL_W 8
`define SEG_VAL_W 4
// reset values
`define CHAN_VAL_RST 8'h00
`define SEG_VAL_RST 4'h0
`define SEL_RST 1'b1
`define KEEP_RST 1'b0
`define SEG_EN_RST 1'b0
// field positions of the line word
`define LOW_LSB 0
`define LOW_MSB 3
`define UP_LSB 4
`define UP_MSB 7
`endif

//--- sweep_state_output_lines.v
`timescale 1ns/1ps
`include "state_lines_regs.vh"
// Notes on behaviour
// - four-bit value per segment per channel
// - segment values need channel segment enable
// - reset clears all segment values
// - upper lines show measured segment value
// - lines follow segment value as measured
// - segment lines hold in hold state
// - segment bit n drives upper line n
// - eight-bit value stored per channel
// - channel writes change only stored value
// - reset clears all channel values
// - lines follow sweeping channel, not edited
// - lines follow channel as sweeps run
// - channel lines hold in hold state
// - select clear gives upper lines to drive
// - channel bit n drives line n
// - upper line select defaults to channel bits
// - keep set holds lines at sweep end
// - segment enable per channel, reset clear
module sweep_state_output_lines (
  // clock and reset
  input wire mclk,
  input wire srst,
  // channel value write and read
  input wire chan_wr,
  input wire [`CHAN_AW-1:0] chan_wr_sel,
  input wire [`CHAN_VAL_W-1:0] chan_wr_data,
  input wire [`CHAN_AW-1:0] chan_rd_sel,
  output reg [`CHAN_VAL_W-1:0] chan_rd_data,
  // segment value write and read
  input wire seg_wr,
  input wire [`CHAN_AW-1:0] seg_wr_chan,
  input wire [`SEG_AW-1:0] seg_wr_seg,
  input wire [`SEG_VAL_W-1:0] seg_wr_data,
  input wire [`CHAN_AW-1:0] seg_rd_chan,
  input wire [`SEG_AW-1:0] seg_rd_seg,
  output wire [`SEG_VAL_W-1:0] seg_rd_data,
  // segment enable per channel
  input wire seg_en_wr,
  input wire [`CHAN_AW-1:0] seg_en_chan,
  input wire seg_en_data,
  output wire [`CHAN_COUNT-1:0] seg_en,
  // global settings
  input wire sel_wr,
  input wire sel_data,
  output reg upper_line_source_select,
  input wire keep_wr,
  input wire keep_data,
  output reg keep_at_end,
  // sweep sequencer status
  input wire sweeping,
  input wire [`CHAN_AW-1:0] sweep_chan,
  input wire segmented,
  input wire [`SEG_AW-1:0] sweep_seg,
  input wire hold,
  // drive port monitor, 4 ports
  input wire [3:0] drive_port_active,
  // connector lines
  output reg [`CHAN_VAL_W-1:0] state_output_lines
);
  // one word per channel, in flops so that reset clears them all in one edge
  reg [`CHAN_VAL_W-1:0] chan_val [0:`CHAN_COUNT-1];
  // segment enable, one bit per channel, shared by all its segments
  reg [`CHAN_COUNT-1:0] seg_en_r;

  // sequencer status delayed one edge to meet the registered segment lookup
  reg sweeping_d;
  reg segmented_d;
  reg [`CHAN_AW-1:0] sweep_chan_d;

  // next value of the connector lines
  reg [`CHAN_VAL_W-1:0] next_lines;
  // live word while a sweep runs, before hold and sweep end are applied
  reg [`CHAN_VAL_W-1:0] live_lines;
  // word stored for the channel that is sweeping now
  wire [`CHAN_VAL_W-1:0] swept_word;
  // segment value takes the upper lines in this cycle
  wire seg_override;
  // channel bits, not drive ports, feed the upper lines
  wire upper_from_chan;
  // registered segment value of the swept channel and segment
  wire [`SEG_VAL_W-1:0] seg_lk;
  // reset loop index
  integer i;

  // upper nibble chooser; priority is segment, then channel bits, then drive ports
  function [`SEG_VAL_W-1:0] pick_upper;
    input [`SEG_VAL_W-1:0] chan_hi;
    input [`SEG_VAL_W-1:0] ports;
    input [`SEG_VAL_W-1:0] seg_val;
    input use_chan;
    input use_seg;
    begin
      pick_upper = chan_hi;
      if (!use_chan) begin
        pick_upper = ports;
      end
      if (use_seg) begin
        pick_upper = seg_val;
      end
    end
  endfunction

  // whole line word; the low half always carries channel bits zero to three
  function [`CHAN_VAL_W-1:0] join_lines;
    input [`CHAN_VAL_W-1:0] word;
    input [`SEG_VAL_W-1:0] upper;
    begin
      join_lines = {upper, word[`LOW_MSB:`LOW_LSB]};
    end
  endfunction

  assign seg_en = seg_en_r;

  segment_value_store u_seg (
    .mclk(mclk),
    .srst(srst),
    .wr(seg_wr),
    .wr_chan(seg_wr_chan),
    .wr_seg(seg_wr_seg),
    .wr_data(seg_wr_data),
    .rd_chan(seg_rd_chan),
    .rd_seg(seg_rd_seg),
    .rd_data(seg_rd_data),
    .lk_chan(sweep_chan),
    .lk_seg(sweep_seg),
    .lk_data(seg_lk)
  );

  // channel values, segment enables and global settings; writes touch only storage
  always @(posedge mclk) begin
    if (srst) begin
      for (i = 0; i < `CHAN_COUNT; i = i + 1) begin
        chan_val[i] <= `CHAN_VAL_RST;
      end
      seg_en_r <= {`CHAN_COUNT{`SEG_EN_RST}};
      upper_line_source_select <= `SEL_RST;
      keep_at_end <= `KEEP_RST;
      chan_rd_data <= `CHAN_VAL_RST;
    end else begin
      if (chan_wr) begin
        chan_val[chan_wr_sel] <= chan_wr_data;
      end
      if (seg_en_wr) begin
        seg_en_r[seg_en_chan] <= seg_en_data;
      end
      if (sel_wr) begin
        upper_line_source_select <= sel_data;
      end
      if (keep_wr) begin
        keep_at_end <= keep_data;
      end
      chan_rd_data <= chan_val[chan_rd_sel];
    end
  end

  // align sequencer status with the one-cycle segment lookup;
  // the cost is one extra edge of latency from sequencer to connector,
  // which external triggers must allow for
  always @(posedge mclk) begin
    if (srst) begin
      sweeping_d <= 1'b0;
      segmented_d <= 1'b0;
      sweep_chan_d <= {`CHAN_AW{1'b0}};
    end else begin
      sweeping_d <= sweeping;
      segmented_d <= segmented;
      sweep_chan_d <= sweep_chan;
    end
  end

  // sweeping channel, its segment override and the upper half source
  assign swept_word = chan_val[sweep_chan_d];
  assign seg_override = segmented_d & seg_en_r[sweep_chan_d];
  assign upper_from_chan = upper_line_source_select;

  // live word of a running sweep; segment bit n lands on upper line n
  always @* begin
    live_lines = join_lines(swept_word, pick_upper(swept_word[`UP_MSB:`UP_LSB],
      drive_port_active, seg_lk, upper_from_chan, seg_override));
  end

  // hold wins over everything but reset, so a finished single sweep keeps its levels;
  // hold is taken undelayed since it needs no lookup
  always @* begin
    next_lines = state_output_lines;
    if (hold) begin
      next_lines = state_output_lines;
    end else if (sweeping_d) begin
      next_lines = live_lines;
    end else if (!keep_at_end) begin
      next_lines = {`CHAN_VAL_W{1'b0}};
    end
  end

  // lines come from a flop so the connector never glitches
  always @(posedge mclk) begin
    if (srst) begin
      state_output_lines <= `CHAN_VAL_RST;
    end else begin
      state_output_lines <= next_lines;
    end
  end
endmodule // sweep_state_output_lines

//--- sweep_state_output_lines_checker.sv
`timescale 1ns/1ps
module sweep_state_output_lines_checker (
  // clock, reset, strobes
  input logic mclk, srst, chan_wr, seg_wr, seg_en_wr, seg_en_data, sel_wr,
  // addresses and data
  input logic [3:0] chan_wr_sel, chan_rd_sel, seg_wr_chan, seg_wr_seg, seg_wr_data,
  input logic [3:0] seg_rd_chan, seg_rd_seg, seg_rd_data, seg_en_chan, sweep_chan,
  input logic [7:0] chan_wr_data, chan_rd_data, state_output_lines,
  // status
  input logic [15:0] seg_en,
  input logic upper_line_source_select, keep_at_end, sweeping, segmented, hold
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // a read of the swept channel lands one edge before the lines do
  wire base = sweeping && !hold && !chan_wr && chan_rd_sel == sweep_chan;
  a_reset_state:
    assert property ($fell(srst) |-> state_output_lines == 8'h00 && seg_en == 16'h0000
      && upper_line_source_select && !keep_at_end) else $error("bad reset");
  a_idle_zero:
    assert property ((!sweeping && !keep_at_end && !hold) [*3] |-> state_output_lines == 8'h00)
      else $error("not cleared");
  a_hold_freeze:
    assert property (hold |=> $stable(state_output_lines)) else $error("moved in hold");
  a_chan_store:
    assert property (chan_wr ##1 (!chan_wr && chan_rd_sel == $past(chan_wr_sel))
      |=> chan_rd_data == $past(chan_wr_data, 2)) else $error("bad channel store");
  a_seg_store:
    assert property (seg_wr ##1 (!seg_wr && seg_rd_chan == $past(seg_wr_chan)
      && seg_rd_seg == $past(seg_wr_seg)) |=> seg_rd_data == $past(seg_wr_data, 2))
      else $error("bad segment store");
  a_en_write:
    assert property (seg_en_wr |=> seg_en[$past(seg_en_chan)] == $past(seg_en_data))
      else $error("bad enable");
  a_low_follow:
    assert property (base ##1 !hold |=> state_output_lines[3:0] == $past(chan_rd_data[3:0]))
      else $error("bad low lines");
  a_upper_chan:
    assert property (base && !segmented && upper_line_source_select && !sel_wr ##1 !hold
      |=> state_output_lines == $past(chan_rd_data)) else $error("bad lines");
  c_seg: cover property (sweeping && segmented && seg_en[sweep_chan]);
  c_hold: cover property (hold && !sweeping);
  c_keep: cover property (keep_at_end && !sweeping);
endmodule // sweep_state_output_lines_checker
bind sweep_state_output_lines sweep_state_output_lines_checker chk_i (.*);

//--- sweep_state_output_lines_tb_top.sv
`timescale 1ns/1ps
module sweep_state_output_lines_tb_top;
  logic mclk = 0, srst = 1, chan_wr = 0, seg_wr = 0, seg_en_wr = 0, seg_en_data = 1;
  logic sel_wr = 0, sel_data = 0, keep_wr = 0, keep_data = 0, sweeping = 0;
  logic segmented = 0, hold = 0, upper_line_source_select, keep_at_end;
  logic [3:0] chan_wr_sel = 0, seg_wr_chan = 4'h3, seg_wr_seg = 4'h2, seg_wr_data = 4'h9;
  logic [3:0] chan_rd_sel = 4'h3, seg_rd_chan = 4'h3, seg_rd_seg = 4'h2, seg_rd_data;
  logic [3:0] seg_en_chan = 4'h3, sweep_chan = 0, sweep_seg = 0, drive_port_active = 4'h6;
  logic [7:0] chan_wr_data = 0, chan_rd_data, state_output_lines, far_seen;
  logic [15:0] seg_en;
  logic [11:0] cv [3] = '{12'h001, 12'h3A5, 12'hF3C};
  // channel, segment, flags (segmented, select), expected lines
  logic [19:0] rows [8] = '{20'h00101, 20'h301A5, 20'hF013C, 20'h32395,
    20'h30305, 20'h30065, 20'hF233C, 20'h32295};
  int err_count = 0, checks_done = 0, cyc = 0;
  sweep_state_output_lines dut (.*);
  line_listener far (.mclk, .lines(state_output_lines), .seen(far_seen));
  initial forever #4 mclk = ~mclk;
  // run needs under 400 cycles
  always @(posedge mclk) if (++cyc == 2000) begin err_count++; test_done; end
  task t(int n); repeat (n) @(negedge mclk); endtask
  // one-cycle strobe; the leading cycle keeps back-to-back calls apart
  task automatic pls(ref logic s); t(1); s = 1; t(1); s = 0; endtask
  task chk(string n, logic [25:0] s, logic [25:0] e);
    checks_done++;
    if (s !== e) begin err_count++; $display("wrong value %s exp %h seen %h", n, e, s); end
  endtask
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    t(10);
    srst = 0;
    t(1);
    chk("idle", {upper_line_source_select, keep_at_end, seg_en, state_output_lines},
      26'h2000000);
    foreach (cv[i]) begin
      {chan_wr_sel, chan_wr_data} = cv[i];
      pls(chan_wr);
    end
    pls(seg_wr);
    {seg_wr_chan, seg_wr_data} = 8'hFC;
    pls(seg_wr);
    pls(seg_en_wr);
    t(1);
    chk("seg", seg_rd_data, 4'h9);
    chk("en", seg_en, 16'h0008);
    foreach (rows[i]) begin
      {sweep_chan, sweep_seg} = rows[i][19:12];
      {segmented, sel_data} = rows[i][9:8];
      sweeping = 1;
      pls(sel_wr);
      t(3);
      chk("lines", far_seen, rows[i][7:0]);
    end
    {chan_wr_sel, chan_wr_data} = 12'h7FF;
    pls(chan_wr);
    t(3);
    chk("other", state_output_lines, 8'h95);
    hold = 1;
    sweeping = 0;
    t(4);
    chk("hold", state_output_lines, 8'h95);
    hold = 0;
    t(4);
    chk("end", state_output_lines, 8'h00);
    keep_data = 1;
    pls(keep_wr);
    sweep_chan = 0;
    sweeping = 1;
    t(3);
    chk("keep", state_output_lines, 8'h61);
    sweeping = 0;
    t(4);
    chk("keep", state_output_lines, 8'h61);
    srst = 1;
    t(2);
    srst = 0;
    t(2);
    chk("rst", {state_output_lines, chan_rd_data, seg_rd_data}, 26'h0);
    test_done;
  end
endmodule // sweep_state_output_lines_tb_top
